/* File: core/lfm_map.svh */
// Offsets, field positions, reset values and timing counts of the loop fault monitor
`ifndef LFM_MAP_SVH
`define LFM_MAP_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define LFM_ADDR_W          8
`define LFM_OFS_CTRL        8'h00
`define LFM_OFS_CMD         8'h04
`define LFM_OFS_FAULT       8'h08
`define LFM_OFS_ADC         8'h0C
`define LFM_OFS_INT_STAT    8'h10
`define LFM_OFS_INT_MASK    8'h14
`define LFM_OFS_STRAP       8'h18
// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define LFM_CTRL_ADC_PWR    7
`define LFM_CTRL_ADC_SEL    8
`define LFM_CTRL_AUTO_RB    9
`define LFM_CMD_CONVERT     8'h08
// ----------------------------------------------------------------
// Fault register fields
// ----------------------------------------------------------------
`define LFM_NFAULT          6
`define LFM_F_UNDER         0
`define LFM_F_OVER          1
`define LFM_F_T100          2
`define LFM_F_T140          3
`define LFM_F_VL12          4
`define LFM_F_VL6           5
`define LFM_FAULT_PIN_MASK  6'h2B
`define LFM_FAULT_ADC_LSB   8
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LFM_RST_MASK        6'h00
// ----------------------------------------------------------------
// Thresholds and timing
// ----------------------------------------------------------------
`define LFM_TOL_PPM         100
`define LFM_FSR_CODES       65536
`define LFM_ILOOP_TOL       ((`LFM_FSR_CODES * `LFM_TOL_PPM) / 1000000)
`define LFM_VLOOP_FS_MV     2500
`define LFM_VL12_SET_MV     600
`define LFM_VL12_CLR_MV     700
`define LFM_VL6_SET_MV      300
`define LFM_VL6_CLR_MV      400
`define LFM_CLK_MHZ         10
`define LFM_BLANK_US        30
`define LFM_BLANK_CYC       (`LFM_BLANK_US * `LFM_CLK_MHZ)
`define LFM_BLANK_W         9
`define LFM_ADC_WAKE_CYC    4
`endif

/* File: core/lfm_pkg.sv */
// Types shared by the loop fault monitor modules
package lfm_pkg;
  // ----------------------------------------------------------------
  // Strap decodes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LFM_RANGE_4_20,
    LFM_RANGE_3P8_21,
    LFM_RANGE_3P2_24
  } lfm_range_t;

  typedef enum logic [2:0] {
    LFM_VREG_1V8,
    LFM_VREG_2V5,
    LFM_VREG_3V0,
    LFM_VREG_3V3,
    LFM_VREG_5V0,
    LFM_VREG_9V0,
    LFM_VREG_12V0,
    LFM_VREG_RSVD
  } lfm_vreg_t;

  // ----------------------------------------------------------------
  // Converter sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LFM_ADC_IDLE,
    LFM_ADC_WAKE,
    LFM_ADC_CONV
  } lfm_adc_st_t;

  typedef struct packed {
    lfm_adc_st_t st;
    logic [3:0]  wake_cnt;
    logic        sel;
    logic        on;
    logic        start;
    logic        res_valid;
    logic        res_sel;
    logic [7:0]  res;
  } lfm_adc_state_t;

  // ----------------------------------------------------------------
  // Monitor state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0]  strap_a;
    logic [4:0]  strap_b;
    logic [4:0]  strap_c;
    logic [4:0]  strap_q;
    lfm_range_t  range;
    lfm_vreg_t   vreg;
    logic        adc_pwr;
    logic        adc_sel;
    logic        auto_rb;
    logic        conv_cmd;
    logic        fault_rd;
    logic [5:0]  fault;
    logic [7:0]  adc_res;
    logic [5:0]  int_stat;
    logic [5:0]  int_mask;
    logic [8:0]  blank_cnt;
    logic        fault_pin;
    logic        irq;
    logic [31:0] rdata;
  } lfm_mon_state_t;
endpackage : lfm_pkg

/* File: core/lfm_adc_seq.sv */
// Sequencer for the on-chip converter: power-up, one conversion, result capture
`timescale 1ns/1ps
`include "lfm_map.svh"
module lfm_adc_seq import lfm_pkg::*; #(
  parameter int WAKE_CYC = `LFM_ADC_WAKE_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       conv_cmd,
  input  wire logic       auto_en,
  input  wire logic       fault_rd,
  input  wire logic       sel,
  input  wire logic       adc_done,
  input  wire logic [7:0] adc_data,
  output logic            adc_on,
  output logic            adc_start,
  output logic            res_valid,
  output logic            res_sel,
  output logic [7:0]      res
);
  lfm_adc_state_t q;
  lfm_adc_state_t next_q;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_q           = q;
    next_q.start     = 1'b0;
    next_q.res_valid = 1'b0;
    case (q.st)
      LFM_ADC_IDLE: begin
        next_q.on = auto_en;
        // Auto mode converts on each fault read that arrives while idle, so the next read sees fresh data
        if (conv_cmd || (auto_en && fault_rd)) begin
          next_q.on       = 1'b1;
          next_q.sel      = sel;
          next_q.wake_cnt = 4'(WAKE_CYC);
          next_q.st       = LFM_ADC_WAKE;
        end
      end
      LFM_ADC_WAKE: begin
        if (q.wake_cnt == 4'h0) begin
          next_q.start = 1'b1;
          next_q.st    = LFM_ADC_CONV;
        end else begin
          next_q.wake_cnt = q.wake_cnt - 4'h1;
        end
      end
      LFM_ADC_CONV: begin
        if (adc_done) begin
          next_q.res       = adc_data;
          next_q.res_sel   = q.sel;
          next_q.res_valid = 1'b1;
          next_q.on        = auto_en;
          next_q.st        = LFM_ADC_IDLE;
        end
      end
      default: next_q.st = LFM_ADC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign adc_on    = q.on;
  assign adc_start = q.start;
  assign res_valid = q.res_valid;
  assign res_sel   = q.res_sel;
  assign res       = q.res;
endmodule : lfm_adc_seq

/* File: core/lfm_fault_monitor.sv */
// Fault monitor and strap decoder of a loop-powered current-output converter
`timescale 1ns/1ps
`include "lfm_map.svh"
module lfm_fault_monitor import lfm_pkg::*; #(
  parameter int         ADC_W     = 8,
  parameter logic [7:0] T100_CODE = 8'hA0,
  parameter logic [7:0] T140_CODE = 8'hC0
) (
  input  wire logic                   sys_clk,
  input  wire logic                   srst,
  input  wire logic [`LFM_ADDR_W-1:0] addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic [31:0]                 rdata,
  input  wire logic [15:0]            loop_prog,
  input  wire logic [15:0]            loop_meas,
  input  wire logic                   span_strap_lsb,
  input  wire logic                   span_strap_msb,
  input  wire logic                   regulator_strap_bit0,
  input  wire logic                   regulator_strap_bit1,
  input  wire logic                   regulator_strap_bit2,
  input  wire logic                   adc_done,
  input  wire logic [7:0]             adc_data,
  output logic                        adc_on,
  output logic                        adc_start,
  output logic                        adc_sel,
  output lfm_range_t                  span_range,
  output lfm_vreg_t                   regulator_level,
  output logic                        fault,
  output logic                        irq
);
  // ----------------------------------------------------------------
  // Thresholds
  // ----------------------------------------------------------------
  localparam logic [16:0] ILOOP_TOL = 17'(`LFM_ILOOP_TOL);
  localparam logic [7:0]  VL12_SET  = 8'((`LFM_VL12_SET_MV * (2 ** ADC_W)) / `LFM_VLOOP_FS_MV);
  localparam logic [7:0]  VL12_CLR  = 8'((`LFM_VL12_CLR_MV * (2 ** ADC_W)) / `LFM_VLOOP_FS_MV);
  localparam logic [7:0]  VL6_SET   = 8'((`LFM_VL6_SET_MV * (2 ** ADC_W)) / `LFM_VLOOP_FS_MV);
  localparam logic [7:0]  VL6_CLR   = 8'((`LFM_VL6_CLR_MV * (2 ** ADC_W)) / `LFM_VLOOP_FS_MV);
  localparam logic [8:0]  BLANK_CYC = 9'(`LFM_BLANK_CYC);

  lfm_mon_state_t q;
  lfm_mon_state_t next_q;
  logic           seq_on;
  logic           seq_start;
  logic           res_valid;
  logic           res_sel;
  logic [7:0]     res;
  logic [16:0]    under_diff;
  logic [16:0]    over_diff;
  logic [5:0]     w1c;

  // ----------------------------------------------------------------
  // Strap decoders
  // ----------------------------------------------------------------
  function automatic lfm_range_t dec_range(input logic [1:0] s);
    case (s)
      2'h0:    dec_range = LFM_RANGE_4_20;
      2'h1:    dec_range = LFM_RANGE_3P8_21;
      2'h2:    dec_range = LFM_RANGE_3P2_24;
      default: dec_range = LFM_RANGE_3P8_21;
    endcase
  endfunction : dec_range

  function automatic lfm_vreg_t dec_vreg(input logic [2:0] s);
    case (s)
      3'h0:    dec_vreg = LFM_VREG_1V8;
      3'h1:    dec_vreg = LFM_VREG_2V5;
      3'h2:    dec_vreg = LFM_VREG_3V0;
      3'h3:    dec_vreg = LFM_VREG_3V3;
      3'h4:    dec_vreg = LFM_VREG_5V0;
      3'h5:    dec_vreg = LFM_VREG_9V0;
      3'h6:    dec_vreg = LFM_VREG_12V0;
      default: dec_vreg = LFM_VREG_RSVD;
    endcase
  endfunction : dec_vreg

  // ----------------------------------------------------------------
  // Converter sequencer
  // ----------------------------------------------------------------
  lfm_adc_seq u_adc_seq (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .conv_cmd  (q.conv_cmd),
    .auto_en   (q.adc_pwr & q.auto_rb),
    .fault_rd  (q.fault_rd),
    .sel       (q.adc_sel),
    .adc_done  (adc_done),
    .adc_data  (adc_data),
    .adc_on    (seq_on),
    .adc_start (seq_start),
    .res_valid (res_valid),
    .res_sel   (res_sel),
    .res       (res)
  );

  assign under_diff = {1'b0, loop_prog} - {1'b0, loop_meas};
  assign over_diff  = {1'b0, loop_meas} - {1'b0, loop_prog};
  assign w1c        = (wr && addr == `LFM_OFS_INT_STAT) ? wdata[5:0] : 6'h00;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_q          = q;
    next_q.conv_cmd = 1'b0;
    next_q.fault_rd = 1'b0;
    next_q.rdata    = 32'h0000_0000;

    // Straps: a change counts once the second and third stages agree
    next_q.strap_a = {regulator_strap_bit2, regulator_strap_bit1, regulator_strap_bit0,
                      span_strap_msb, span_strap_lsb};
    next_q.strap_b = q.strap_a;
    next_q.strap_c = q.strap_b;
    if (q.strap_b == q.strap_c) begin
      next_q.strap_q = q.strap_c;
    end
    next_q.range = dec_range(q.strap_q[1:0]);
    next_q.vreg  = dec_vreg(q.strap_q[4:2]);

    // Register writes
    if (wr) begin
      case (addr)
        `LFM_OFS_CTRL: begin
          next_q.adc_pwr = wdata[`LFM_CTRL_ADC_PWR];
          next_q.adc_sel = wdata[`LFM_CTRL_ADC_SEL];
          next_q.auto_rb = wdata[`LFM_CTRL_AUTO_RB];
          // Mux settling can glitch the comparators, so freeze the pin meanwhile
          if (!q.adc_sel && wdata[`LFM_CTRL_ADC_SEL]) begin
            next_q.blank_cnt = BLANK_CYC;
          end
        end
        `LFM_OFS_CMD: begin
          next_q.conv_cmd = (wdata[7:0] == `LFM_CMD_CONVERT);
        end
        `LFM_OFS_INT_MASK: begin
          next_q.int_mask = wdata[5:0];
        end
        default: begin
        end
      endcase
    end
    if (q.blank_cnt != 9'h000 && next_q.blank_cnt == q.blank_cnt) begin
      next_q.blank_cnt = q.blank_cnt - 9'h001;
    end

    // Register reads
    if (rd) begin
      case (addr)
        `LFM_OFS_CTRL: begin
          next_q.rdata[`LFM_CTRL_ADC_PWR] = q.adc_pwr;
          next_q.rdata[`LFM_CTRL_ADC_SEL] = q.adc_sel;
          next_q.rdata[`LFM_CTRL_AUTO_RB] = q.auto_rb;
        end
        `LFM_OFS_FAULT: begin
          next_q.rdata[5:0]   = q.fault;
          next_q.rdata[15:8]  = q.adc_res;
          next_q.fault_rd     = 1'b1;
        end
        `LFM_OFS_ADC:      next_q.rdata[7:0] = q.adc_res;
        `LFM_OFS_INT_STAT: next_q.rdata[5:0] = q.int_stat;
        `LFM_OFS_INT_MASK: next_q.rdata[5:0] = q.int_mask;
        `LFM_OFS_STRAP: begin
          next_q.rdata[1:0] = q.range;
          next_q.rdata[6:4] = q.vreg;
        end
        default: next_q.rdata = 32'h0000_0000;
      endcase
    end

    // Loop current comparison, live every cycle
    next_q.fault[`LFM_F_UNDER] = (loop_meas < loop_prog) && (under_diff > ILOOP_TOL);
    next_q.fault[`LFM_F_OVER]  = (loop_meas > loop_prog) && (over_diff > ILOOP_TOL);

    // Converter results update only the bits of the input that was measured
    if (res_valid) begin
      next_q.adc_res = res;
      if (res_sel) begin
        next_q.fault[`LFM_F_T100] = res > T100_CODE;
        next_q.fault[`LFM_F_T140] = res > T140_CODE;
      end else begin
        if (res < VL12_SET) begin
          next_q.fault[`LFM_F_VL12] = 1'b1;
        end else if (res > VL12_CLR) begin
          next_q.fault[`LFM_F_VL12] = 1'b0;
        end
        if (res < VL6_SET) begin
          next_q.fault[`LFM_F_VL6] = 1'b1;
        end else if (res > VL6_CLR) begin
          next_q.fault[`LFM_F_VL6] = 1'b0;
        end
      end
    end

    // Sticky event bits; a new event wins over a same-cycle clear
    next_q.int_stat = (q.int_stat & ~w1c) | (next_q.fault & ~q.fault);
    next_q.irq      = |(next_q.int_stat & next_q.int_mask);

    // Fault pin held steady while blanked; real faults show once it ends
    if (q.blank_cnt == 9'h000) begin
      next_q.fault_pin = |(next_q.fault & `LFM_FAULT_PIN_MASK);
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q          <= '0;
      q.int_mask <= `LFM_RST_MASK;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata           = q.rdata;
  assign adc_on          = seq_on;
  assign adc_start       = seq_start;
  assign adc_sel         = q.adc_sel;
  assign span_range      = q.range;
  assign regulator_level = q.vreg;
  assign fault           = q.fault_pin;
  assign irq             = q.irq;
endmodule : lfm_fault_monitor

/* File: verification/lfm_fault_monitor_props.sv */
// Port-level checks of the loop fault monitor, bound to its top module
`timescale 1ns/1ps
`include "lfm_map.svh"
module lfm_fault_monitor_props import lfm_pkg::*; (
  input wire logic                   sys_clk,
  input wire logic                   srst,
  input wire logic [`LFM_ADDR_W-1:0] addr,
  input wire logic [31:0]            wdata,
  input wire logic                   wr,
  input wire logic                   rd,
  input wire logic [31:0]            rdata,
  input wire logic [15:0]            loop_prog,
  input wire logic [15:0]            loop_meas,
  input wire logic                   span_strap_lsb,
  input wire logic                   span_strap_msb,
  input wire logic                   regulator_strap_bit0,
  input wire logic                   regulator_strap_bit1,
  input wire logic                   regulator_strap_bit2,
  input wire logic                   adc_done,
  input wire logic [7:0]             adc_data,
  input wire logic                   adc_on,
  input wire logic                   adc_start,
  input wire logic                   adc_sel,
  input wire lfm_range_t             span_range,
  input wire lfm_vreg_t              regulator_level,
  input wire logic                   fault,
  input wire logic                   irq
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic signed [16:0] gap;
  logic [8:0]         blk;
  logic [3:0]         calm;
  logic [4:0]         strap_d;
  logic               mask_any;
  wire logic [4:0]    strap_now = {regulator_strap_bit2, regulator_strap_bit1, regulator_strap_bit0,
                                   span_strap_msb, span_strap_lsb};
  assign gap = $signed({1'b0, loop_meas}) - $signed({1'b0, loop_prog});
  wire logic          loop_bad = (gap > 17'sh00006) || (gap < -17'sh00006);
  // Pin is frozen after a switch to temperature, so loop checks pause a little longer
  always_ff @(posedge sys_clk) begin
    strap_d <= strap_now;
    if (srst) begin
      blk      <= 9'h000;
      calm     <= 4'h0;
      mask_any <= 1'b0;
    end else begin
      blk  <= $rose(adc_sel) ? 9'h136 : ((blk != 9'h000) ? blk - 9'h001 : blk);
      calm <= (strap_d != strap_now) ? 4'h0 : ((calm != 4'hF) ? calm + 4'h1 : calm);
      if (wr && addr == `LFM_OFS_INT_MASK) mask_any <= |wdata[5:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
    else $error("read data seen outside its slot");
  a_loop_fault_pin: assert property (loop_bad [*3] ##0 blk == 9'h000 |-> fault)
    else $error("loop current error without fault pin");
  a_adc_wake: assert property (wr && addr == `LFM_OFS_CMD && wdata[7:0] == `LFM_CMD_CONVERT && !adc_on
    |-> ##2 adc_on ##5 adc_start)
    else $error("convert command did not power and start converter");
  a_start_pulse: assert property (adc_start |=> !adc_start)
    else $error("start pulse longer than one cycle");
  a_start_powered: assert property (adc_start |-> adc_on)
    else $error("start without converter power");
  a_irq_masked: assert property (!mask_any && !$past(mask_any) |-> !irq)
    else $error("interrupt with all sources masked");
  a_span_decode: assert property (calm >= 4'hA |-> span_range == (strap_d[1:0] == 2'b10 ? LFM_RANGE_3P2_24 :
    (strap_d[1:0] == 2'b00 ? LFM_RANGE_4_20 : LFM_RANGE_3P8_21)))
    else $error("range strap decode wrong");
  a_vreg_decode: assert property (calm >= 4'hA |-> regulator_level == lfm_vreg_t'(strap_d[4:2]))
    else $error("regulator strap decode wrong");
  a_sel_follows: assert property (wr && addr == `LFM_OFS_CTRL |=> adc_sel == $past(wdata[`LFM_CTRL_ADC_SEL]))
    else $error("converter select does not follow control write");
  a_blank_hold: assert property (blk >= 9'h010 |-> $stable(fault))
    else $error("fault pin moved while blanked");
endmodule : lfm_fault_monitor_props

bind lfm_fault_monitor lfm_fault_monitor_props lfm_fault_monitor_props_i (
  .sys_clk(sys_clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .loop_prog(loop_prog), .loop_meas(loop_meas), .span_strap_lsb(span_strap_lsb), .span_strap_msb(span_strap_msb),
  .regulator_strap_bit0(regulator_strap_bit0), .regulator_strap_bit1(regulator_strap_bit1),
  .regulator_strap_bit2(regulator_strap_bit2), .adc_done(adc_done), .adc_data(adc_data), .adc_on(adc_on),
  .adc_start(adc_start), .adc_sel(adc_sel), .span_range(span_range), .regulator_level(regulator_level),
  .fault(fault), .irq(irq));

/* File: verification/lfm_adc_model.sv */
// Behavioural converter answering the start pulse after a chosen latency
`timescale 1ns/1ps
module lfm_adc_model (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       adc_on,
  input  wire logic       adc_start,
  input  wire logic [4:0] lat,
  input  wire logic [7:0] code,
  output logic            adc_done,
  output logic [7:0]      adc_data
);
  logic [4:0] cnt;
  logic       busy;
  always_ff @(posedge sys_clk) begin
    adc_done <= 1'b0;
    // Data toggle outside the done cycle so a stale value never looks valid
    adc_data <= ~adc_data;
    if (srst) begin
      busy     <= 1'b0;
      adc_data <= 8'h00;
    end else if (adc_start && adc_on) begin
      busy <= 1'b1;
      cnt  <= lat;
    end else if (busy) begin
      if (cnt == 5'h00) begin
        busy     <= 1'b0;
        adc_done <= 1'b1;
        adc_data <= code;
      end else begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule : lfm_adc_model

/* File: verification/lfm_fault_monitor_tb.sv */
// Self-checking bench for the loop fault monitor
`timescale 1ns/1ps
`include "lfm_map.svh"
module lfm_fault_monitor_tb import lfm_pkg::*;;
  logic        sys_clk   = 1'b0;
  logic        srst      = 1'b1;
  logic [7:0]  addr      = 8'h00;
  logic [31:0] wdata     = 32'h0000_0000;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic [15:0] loop_prog = 16'h1000;
  logic [15:0] loop_meas = 16'h1000;
  logic [4:0]  strap     = 5'h00;
  logic [4:0]  lat       = 5'h00;
  logic [7:0]  code      = 8'h00;
  logic [31:0] r         = 32'h0001_3399; // Seed 78745
  logic [1:0]  vl        = 2'b00;
  logic [31:0] rdata, d;
  logic [7:0]  adc_data;
  logic        adc_done, adc_on, adc_start, adc_sel, fault, irq;
  lfm_range_t  span_range;
  lfm_vreg_t   regulator_level;
  int          err_count = 0;
  int          compares  = 0;
  logic [7:0]  vcodes[11] = '{8'hC8, 8'h3D, 8'h3C, 8'h41, 8'h47, 8'h48, 8'h1E, 8'h1D, 8'h28, 8'h29, 8'hC8};
  logic [15:0] offs[5]    = '{16'hFFF9, 16'hFFFA, 16'h0000, 16'h0006, 16'h0007};

  lfm_fault_monitor lfm_fault_monitor_i (
    .sys_clk(sys_clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .loop_prog(loop_prog), .loop_meas(loop_meas), .span_strap_lsb(strap[0]), .span_strap_msb(strap[1]),
    .regulator_strap_bit0(strap[2]), .regulator_strap_bit1(strap[3]), .regulator_strap_bit2(strap[4]),
    .adc_done(adc_done), .adc_data(adc_data), .adc_on(adc_on), .adc_start(adc_start), .adc_sel(adc_sel),
    .span_range(span_range), .regulator_level(regulator_level), .fault(fault), .irq(irq));
  lfm_adc_model lfm_adc_model_i (.sys_clk(sys_clk), .srst(srst), .adc_on(adc_on), .adc_start(adc_start),
    .lat(lat), .code(code), .adc_done(adc_done), .adc_data(adc_data));

  always #50 sys_clk = ~sys_clk;
  // ----------------------------------------------------------------
  // Expectations and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [1:0] loop_exp(input logic [15:0] p, input logic [15:0] m);
    return {{1'b0, m} > {1'b0, p} + 17'h00006, {1'b0, m} + 17'h00006 < {1'b0, p}};
  endfunction : loop_exp
  function automatic logic [1:0] vl_exp(input logic [1:0] cur, input logic [7:0] c);
    return {c < 8'h1E ? 1'b1 : (c > 8'h28 ? 1'b0 : cur[1]), c < 8'h3D ? 1'b1 : (c > 8'h47 ? 1'b0 : cur[0])};
  endfunction : vl_exp
  function automatic logic [1:0] span_exp(input logic [1:0] s);
    return (s == 2'b10) ? 2'h2 : ((s == 2'b00) ? 2'h0 : 2'h1);
  endfunction : span_exp
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask : rd_reg
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle
  task automatic convert(input logic [7:0] c, input logic sel, input logic aut = 1'b0);
    int         i;
    logic [1:0] t;
    r = xs(r);
    code <= c;
    lat  <= r[4:0];
    if (aut) rd_reg(`LFM_OFS_FAULT);
    else wr_reg(`LFM_OFS_CMD, 32'h0000_0008);
    for (i = 0; i < 80 && adc_done !== 1'b1; i++) @(negedge sys_clk);
    chk("adc_done", 32'h1, 32'(adc_done));
    settle(3);
    t = sel ? {c > 8'hC0, c > 8'hA0} : 2'b00;
    if (!sel) vl = vl_exp(vl, c);
    rd_reg(`LFM_OFS_FAULT);
    chk("fault_reg", {16'h0000, c, 2'b00, vl, t, 2'b00}, {16'h0000, d[15:0]});
    chk("fault_pin", 32'(vl[1] | t[1]), 32'(fault));
  endtask : convert
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #1_000_000;
    $display("watchdog expired");
    err_count++;
    print_verdict();
  end
  initial begin
    logic [1:0] e;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    rd_reg(`LFM_OFS_INT_MASK);
    chk("mask_reset", 32'h0, d);
    wr_reg(8'h1C, 32'hFFFF_FFFF);
    rd_reg(8'h1C);
    chk("unmapped", 32'h0, d);
    $display("test reset done");
    foreach (vcodes[k]) convert(vcodes[k], 1'b0);
    $display("test loop voltage done");
    for (int k = 0; k < 30; k++) begin
      r = xs(r);
      @(posedge sys_clk);
      loop_prog <= 16'h0100 + {1'b0, r[30:16]};
      loop_meas <= 16'h0100 + {1'b0, r[30:16]} + ((k % 6 == 5) ? {10'h000, r[5:0]} - 16'h0020 : offs[k % 6]);
      settle(3);
      e = loop_exp(loop_prog, loop_meas);
      chk("loop_pin", 32'(e[0] | e[1]), 32'(fault));
      rd_reg(`LFM_OFS_FAULT);
      chk("loop_bits", 32'(e), 32'(d[1:0]));
    end
    $display("test loop current done");
    @(posedge sys_clk);
    loop_meas <= loop_prog;
    wr_reg(`LFM_OFS_INT_STAT, 32'h0000_003F);
    wr_reg(`LFM_OFS_INT_MASK, 32'h0000_0003);
    @(posedge sys_clk);
    loop_meas <= loop_prog - 16'h0010;
    settle(3);
    chk("irq_set", 32'h1, 32'(irq));
    rd_reg(`LFM_OFS_INT_STAT);
    chk("stat_under", 32'h1, 32'(d[5:0]));
    @(posedge sys_clk);
    loop_meas <= loop_prog;
    settle(2);
    wr_reg(`LFM_OFS_INT_STAT, 32'h0000_0001);
    settle(2);
    chk("irq_clear", 32'h0, 32'(irq));
    wr_reg(`LFM_OFS_INT_MASK, 32'h0000_0000);
    loop_meas <= loop_prog + 16'h0010;
    settle(3);
    chk("irq_masked", 32'h0, 32'(irq));
    chk("over_pin", 32'h1, 32'(fault));
    rd_reg(`LFM_OFS_INT_STAT);
    chk("stat_over", 32'h2, 32'(d[5:0]));
    @(posedge sys_clk);
    loop_meas <= loop_prog;
    settle(2);
    chk("pin_falls", 32'h0, 32'(fault));
    wr_reg(`LFM_OFS_INT_STAT, 32'h0000_003F);
    $display("test interrupt done");
    wr_reg(`LFM_OFS_CTRL, 32'h0000_0100);
    loop_meas <= loop_prog - 16'h0010;
    settle(3);
    chk("blank_pin", 32'h0, 32'(fault));
    rd_reg(`LFM_OFS_FAULT);
    chk("blank_bits", 32'h1, 32'(d[1:0]));
    @(posedge sys_clk);
    loop_meas <= loop_prog;
    repeat (310) @(posedge sys_clk);
    convert(8'hB0, 1'b1);
    convert(8'hD0, 1'b1);
    convert(8'h10, 1'b1);
    wr_reg(`LFM_OFS_CTRL, 32'h0000_0380);
    settle(2);
    chk("auto_power", 32'h1, 32'(adc_on));
    convert(8'hC8, 1'b1, 1'b1);
    wr_reg(`LFM_OFS_CTRL, 32'h0000_0000);
    $display("test temperature done");
    for (int k = 0; k < 32; k++) begin
      @(posedge sys_clk);
      strap <= k[4:0];
      settle(8);
      chk("span", 32'(span_exp(strap[1:0])), 32'(span_range));
      chk("vreg", 32'(strap[4:2]), 32'(regulator_level));
      rd_reg(`LFM_OFS_STRAP);
      chk("strap_reg", {25'h0, strap[4:2], 2'b00, span_exp(strap[1:0])}, d);
    end
    $display("test straps done");
    print_verdict();
  end
endmodule : lfm_fault_monitor_tb
